// File: design/osc_pkg.sv
// constants, opcodes, states and crc step for the status-field command block
package osc_pkg;

  // timing, in ns as printed, and the derived cycle counts at 50 MHz
  localparam int          OSC_CLK_NS        = 20;
  localparam int          OSC_RESET_NS      = 480000;
  localparam int          OSC_WR0_NS        = 15000;
  localparam int          OSC_TX_HOLD_NS    = 30000;
  localparam int          OSC_PRES_WAIT_NS  = 30000;
  localparam int          OSC_PRES_LEN_NS   = 120000;
  localparam logic [15:0] OSC_RESET_CYC     = 16'((OSC_RESET_NS + OSC_CLK_NS - 1) / OSC_CLK_NS);
  localparam logic [15:0] OSC_WR0_CYC       = 16'((OSC_WR0_NS + OSC_CLK_NS - 1) / OSC_CLK_NS);
  localparam logic [15:0] OSC_TX_HOLD_CYC   = 16'(OSC_TX_HOLD_NS / OSC_CLK_NS);
  localparam logic [15:0] OSC_PRES_WAIT_CYC = 16'((OSC_PRES_WAIT_NS + OSC_CLK_NS - 1) / OSC_CLK_NS);
  localparam logic [15:0] OSC_PRES_LEN_CYC  = 16'(OSC_PRES_LEN_NS / OSC_CLK_NS);

  // rom level opcodes
  localparam logic [7:0] OSC_OP_READ_ROM   = 8'h33;
  localparam logic [7:0] OSC_OP_MATCH_ROM  = 8'h55;
  localparam logic [7:0] OSC_OP_SEARCH_ROM = 8'hf0;
  localparam logic [7:0] OSC_OP_SKIP_ROM   = 8'hcc;
  // function level opcodes
  localparam logic [7:0] OSC_OP_READ_FIELD = 8'hf0;
  localparam logic [7:0] OSC_OP_READ_PAGE  = 8'hc3;
  localparam logic [7:0] OSC_OP_WRITE_MEM  = 8'h0f;
  localparam logic [7:0] OSC_OP_PROFILE    = 8'h99;
  localparam logic [7:0] OSC_OP_READ_STAT  = 8'haa;
  localparam logic [7:0] OSC_OP_WRITE_STAT = 8'h55;
  localparam logic [7:0] OSC_OP_PROG_CTRL  = 8'h5a;

  // field contents
  localparam logic [7:0] OSC_PROFILE_BYTE  = 8'h55;
  localparam logic [7:0] OSC_FIXED_BYTE    = 8'h00;
  localparam logic [7:0] OSC_ERASED_BYTE   = 8'hff;
  localparam logic [2:0] OSC_LAST_INDEX    = 3'h7;
  localparam int         OSC_PROG_BYTES    = 7;
  // x^8 + x^5 + x^4 + 1, reflected for lsb-first shifting
  localparam logic [7:0] OSC_CRC_POLY      = 8'h8c;
  localparam logic [6:0] OSC_LAST_BIT      = 7'h07;
  localparam logic [6:0] OSC_LAST_ADDR_BIT = 7'h0f;
  localparam logic [6:0] OSC_LAST_ROM_BIT  = 7'h3f;

  typedef enum logic [13:0] {
    OSC_S_IDLE     = 14'h0001,
    OSC_S_ROMCMD   = 14'h0002,
    OSC_S_ROMTX    = 14'h0004,
    OSC_S_ROMMATCH = 14'h0008,
    OSC_S_FUNC     = 14'h0010,
    OSC_S_ADDR     = 14'h0020,
    OSC_S_DATA     = 14'h0040,
    OSC_S_TXCRC    = 14'h0080,
    OSC_S_PCTL     = 14'h0100,
    OSC_S_PROG     = 14'h0200,
    OSC_S_VERIFY   = 14'h0400,
    OSC_S_RDATA    = 14'h0800,
    OSC_S_RCRC     = 14'h1000,
    OSC_S_PROFILE  = 14'h2000
  } osc_state_t;

  function automatic logic [7:0] osc_crc_step(input logic [7:0] crc, input logic din);
    logic fb;
    fb = crc[0] ^ din;
    return (crc >> 1) ^ (fb ? OSC_CRC_POLY : 8'h00);
  endfunction

endpackage

// File: design/osc_status_mem.sv
// eight-byte status field, seven one-time-programmable bytes and a fixed zero byte, with registered read port
`timescale 1ns/1ps
module osc_status_mem
  import osc_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  input  wire logic       ce_in,
  input  wire logic [2:0] addr_in,
  input  wire logic       prog_in,
  input  wire logic [7:0] prog_data_in,
  output logic      [7:0] rd_data_out
);

  typedef struct packed {
    logic [OSC_PROG_BYTES-1:0][7:0] cells;
    logic [7:0]                     rd;
  } osc_mem_t;

  osc_mem_t                       r;
  osc_mem_t                       next_r;
  logic [OSC_PROG_BYTES-1:0][7:0] prog_val;

  // a pulse can only pull bits to zero, never back to one
  genvar i;
  generate
    for (i = 0; i < OSC_PROG_BYTES; i++) begin : g_cell
      assign prog_val[i] = (prog_in && addr_in == 3'(i)) ? (r.cells[i] & prog_data_in) : r.cells[i];
    end
  endgenerate

  always_comb begin
    next_r       = r;
    next_r.cells = prog_val;
    next_r.rd    = (addr_in == OSC_LAST_INDEX) ? OSC_FIXED_BYTE : r.cells[addr_in];
  end

  // reset here stands for power-up only: the bus reset pulse never touches the cells
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      r <= {{OSC_PROG_BYTES{OSC_ERASED_BYTE}}, OSC_ERASED_BYTE};
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  assign rd_data_out = r.rd;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  a_fixed_byte_read: assert property (ce_in && addr_in == OSC_LAST_INDEX |=> rd_data_out == OSC_FIXED_BYTE)
    else $error("factory byte did not read as zero");
  a_prog_and_only: assert property (ce_in && prog_in && addr_in != OSC_LAST_INDEX ##1 ce_in && $stable(addr_in)
    |=> rd_data_out == ($past(rd_data_out, 2) & $past(prog_data_in, 2)))
    else $error("programming did not clear exactly the zero bits");

endmodule

// File: design/osc_status_cmd.sv
// single-wire command interpreter for the status field: slot decode, rom level, status read/write, profile
`timescale 1ns/1ps
module osc_status_cmd
  import osc_pkg::*;
#(
  parameter logic [15:0] RESET_CYC     = OSC_RESET_CYC,
  parameter logic [15:0] PRES_LEN_CYC  = OSC_PRES_LEN_CYC,
  parameter logic [15:0] WR0_CYC       = OSC_WR0_CYC,
  parameter logic [15:0] TX_HOLD_CYC   = OSC_TX_HOLD_CYC,
  parameter logic [15:0] PRES_WAIT_CYC = OSC_PRES_WAIT_CYC,
  parameter logic [63:0] ROM_ID        = 64'h5a3c_0000_0000_0101  // arbitrary value
)(
  input  wire logic sys_clk_in,
  input  wire logic reset_in,
  input  wire logic ce_in,
  input  wire logic data_line_in,
  input  wire logic prog_level_in,
  output logic      data_out,
  output logic      data_oe_out
);

  typedef struct packed {
    logic        line_s0;
    logic        line_s1;
    logic        line_q;
    logic        prog_s0;
    logic        prog_s1;
    logic        prog_q;
    logic [15:0] low_cnt;
    logic [15:0] drv_cnt;
    logic [15:0] wait_cnt;
    logic        pres;
    osc_state_t  st;
    logic [6:0]  bcnt;
    logic [7:0]  shreg;
    logic [7:0]  wdata;
    logic [7:0]  op;
    logic [15:0] addr;
    logic [7:0]  crc;
    logic        miss;
    logic        prog_go;
  } osc_cmd_t;

  osc_cmd_t   r;
  osc_cmd_t   next_r;
  logic [7:0] mem_rd;
  logic       fall;
  logic       rise;
  logic       reset_evt;
  logic       slot_evt;
  logic       wbit;
  logic       is_tx;
  logic       tx_bit;
  logic       byte_end;
  logic [7:0] rx_byte;
  logic [15:0] addr_inc;

  osc_status_mem u_mem (
    .sys_clk_in   (sys_clk_in),
    .reset_in     (reset_in),
    .ce_in        (ce_in),
    .addr_in      (r.addr[2:0]),
    .prog_in      (r.prog_go),
    .prog_data_in (r.wdata),
    .rd_data_out  (mem_rd)
  );

  // edges of the synchronised line; presence time is ours, so host edges are ignored then
  assign fall      = r.line_q && !r.line_s1 && !r.pres;
  assign rise      = !r.line_q && r.line_s1 && !r.pres;
  assign reset_evt = rise && r.low_cnt >= RESET_CYC;
  assign slot_evt  = rise && !reset_evt;
  assign wbit      = r.low_cnt < WR0_CYC;
  assign byte_end  = r.bcnt == OSC_LAST_BIT;
  assign rx_byte   = {wbit, r.shreg[7:1]};
  assign addr_inc  = r.addr + 16'h0001;

  assign is_tx = r.st inside {OSC_S_ROMTX, OSC_S_TXCRC, OSC_S_RDATA, OSC_S_RCRC, OSC_S_VERIFY, OSC_S_PROFILE};

  always_comb begin
    tx_bit = 1'b1;
    if (r.st == OSC_S_ROMTX) begin
      tx_bit = ROM_ID[r.bcnt[5:0]];
    end else if (r.st == OSC_S_TXCRC || r.st == OSC_S_RCRC) begin
      tx_bit = r.crc[r.bcnt[2:0]];
    end else if (r.st == OSC_S_RDATA || r.st == OSC_S_VERIFY) begin
      tx_bit = mem_rd[r.bcnt[2:0]];
    end else if (r.st == OSC_S_PROFILE) begin
      tx_bit = OSC_PROFILE_BYTE[r.bcnt[2:0]];
    end
  end

  always_comb begin
    next_r         = r;
    next_r.line_s0 = data_line_in;
    next_r.line_s1 = r.line_s0;
    next_r.line_q  = r.line_s1;
    next_r.prog_s0 = prog_level_in;
    next_r.prog_s1 = r.prog_s0;
    next_r.prog_q  = r.prog_s1;
    next_r.prog_go = 1'b0;

    // low-time meter, saturating so a stuck-low line cannot wrap into a short slot
    if (fall) begin
      next_r.low_cnt = 16'h0001;
    end else if (!r.line_s1 && r.low_cnt != 16'hffff) begin
      next_r.low_cnt = r.low_cnt + 16'h0001;
    end
    if (r.drv_cnt != 16'h0000) begin
      next_r.drv_cnt = r.drv_cnt - 16'h0001;
    end

    // presence: wait, drive low, then skip the rising edge we caused
    if (r.pres) begin
      if (r.wait_cnt > 16'h0001) begin
        next_r.wait_cnt = r.wait_cnt - 16'h0001;
      end else if (r.wait_cnt == 16'h0001) begin
        next_r.wait_cnt = 16'h0000;
        next_r.drv_cnt  = PRES_LEN_CYC;
      end else if (r.drv_cnt == 16'h0000 && r.line_s1) begin
        next_r.pres = 1'b0;
      end
    end

    // a read slot of a zero bit is stretched low by us from its falling edge
    if (fall && is_tx && !tx_bit) begin
      next_r.drv_cnt = TX_HOLD_CYC;
    end

    if (reset_evt) begin
      next_r.st       = OSC_S_ROMCMD;
      next_r.bcnt     = 7'h00;
      next_r.pres     = 1'b1;
      next_r.wait_cnt = PRES_WAIT_CYC;
      next_r.miss     = 1'b0;
    end else if (r.st == OSC_S_PROG) begin
      // end of the programming pulse; cells update whatever the crc was
      if (r.prog_q && !r.prog_s1) begin
        next_r.prog_go = 1'b1;
        next_r.st      = OSC_S_VERIFY;
        next_r.bcnt    = 7'h00;
      end
    end else if (slot_evt) begin
      next_r.bcnt = r.bcnt + 7'h01;
      if (!is_tx) begin
        next_r.shreg = rx_byte;
      end
      if (r.st inside {OSC_S_FUNC, OSC_S_ADDR, OSC_S_DATA}) begin
        next_r.crc = osc_crc_step(r.crc, wbit);
      end
      unique case (r.st)
        OSC_S_IDLE: begin
          next_r.bcnt = 7'h00;
        end
        OSC_S_ROMCMD: begin
          if (byte_end) begin
            next_r.bcnt = 7'h00;
            next_r.crc  = 8'h00;
            if (rx_byte == OSC_OP_SKIP_ROM) begin
              next_r.st = OSC_S_FUNC;
            end else if (rx_byte == OSC_OP_READ_ROM) begin
              next_r.st = OSC_S_ROMTX;
            end else if (rx_byte == OSC_OP_MATCH_ROM) begin
              next_r.st = OSC_S_ROMMATCH;
            end else begin
              // search and unknown codes leave the device quiet until reset
              next_r.st = OSC_S_IDLE;
            end
          end
        end
        OSC_S_ROMTX: begin
          if (r.bcnt == OSC_LAST_ROM_BIT) begin
            next_r.st   = OSC_S_FUNC;
            next_r.bcnt = 7'h00;
          end
        end
        OSC_S_ROMMATCH: begin
          if (r.bcnt == OSC_LAST_ROM_BIT) begin
            next_r.st   = (r.miss || wbit != ROM_ID[63]) ? OSC_S_IDLE : OSC_S_FUNC;
            next_r.bcnt = 7'h00;
          end else if (wbit != ROM_ID[r.bcnt[5:0]]) begin
            next_r.miss = 1'b1;
          end
        end
        OSC_S_FUNC: begin
          if (byte_end) begin
            next_r.op   = rx_byte;
            next_r.bcnt = 7'h00;
            if (rx_byte == OSC_OP_READ_STAT || rx_byte == OSC_OP_WRITE_STAT) begin
              next_r.st = OSC_S_ADDR;
            end else if (rx_byte == OSC_OP_PROFILE) begin
              next_r.st = OSC_S_PROFILE;
            end else begin
              // data-memory commands are served by another block
              next_r.st = OSC_S_IDLE;
            end
          end
        end
        OSC_S_ADDR: begin
          next_r.addr = {wbit, r.addr[15:1]};
          if (r.bcnt == OSC_LAST_ADDR_BIT) begin
            next_r.bcnt = 7'h00;
            next_r.st   = (r.op == OSC_OP_READ_STAT) ? OSC_S_TXCRC : OSC_S_DATA;
          end
        end
        OSC_S_DATA: begin
          if (byte_end) begin
            next_r.st   = OSC_S_TXCRC;
            next_r.wdata = rx_byte;
            next_r.bcnt = 7'h00;
          end
        end
        OSC_S_TXCRC: begin
          if (byte_end) begin
            next_r.bcnt = 7'h00;
            if (r.op == OSC_OP_READ_STAT) begin
              next_r.st  = OSC_S_RDATA;
              next_r.crc = 8'h00;
            end else begin
              next_r.st = OSC_S_PCTL;
            end
          end
        end
        OSC_S_PCTL: begin
          if (byte_end) begin
            next_r.bcnt  = 7'h00;
            next_r.st    = (rx_byte == OSC_OP_PROG_CTRL) ? OSC_S_PROG : OSC_S_IDLE;
          end
        end
        OSC_S_VERIFY: begin
          if (byte_end) begin
            next_r.addr = addr_inc;
            next_r.crc  = addr_inc[7:0];
            next_r.st   = OSC_S_DATA;
            next_r.bcnt = 7'h00;
          end
        end
        OSC_S_RDATA: begin
          next_r.crc = osc_crc_step(r.crc, tx_bit);
          if (byte_end) begin
            next_r.bcnt = 7'h00;
            if (r.addr[2:0] == OSC_LAST_INDEX) begin
              next_r.st = OSC_S_RCRC;
            end else begin
              next_r.addr = addr_inc;
            end
          end
        end
        OSC_S_RCRC, OSC_S_PROFILE: begin
          if (byte_end) begin
            next_r.st   = OSC_S_IDLE;
            next_r.bcnt = 7'h00;
          end
        end
        OSC_S_PROG: begin
          next_r.bcnt = r.bcnt;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      r          <= '0;
      r.line_s0  <= 1'b1;
      r.line_s1  <= 1'b1;
      r.line_q   <= 1'b1;
      r.st       <= OSC_S_IDLE;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  // open drain: only ever pulls low
  assign data_out    = 1'b0;
  assign data_oe_out = r.drv_cnt != 16'h0000;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  a_reset_aborts: assert property (ce_in && reset_evt |=> r.st == OSC_S_ROMCMD && r.pres && r.bcnt == 7'h00)
    else $error("reset pulse did not restart the command sequence");
  a_presence_follows: assert property (ce_in && r.pres && r.wait_cnt == 16'h0001 ##1 ce_in |=> data_oe_out)
    else $error("presence pulse not driven after wait");
  a_zero_bit_drives: assert property (ce_in && fall && is_tx && !tx_bit |=> data_oe_out)
    else $error("zero read bit not driven low");
  a_ones_when_idle: assert property (ce_in && fall && r.st == OSC_S_IDLE && !data_oe_out |=> !data_oe_out)
    else $error("device drove a slot after the sequence ended");
  a_status_decode: assert property (ce_in && slot_evt && r.st == OSC_S_FUNC && byte_end
    && rx_byte == OSC_OP_READ_STAT |=> r.st == OSC_S_ADDR && r.op == OSC_OP_READ_STAT)
    else $error("status read opcode not decoded");
  a_verify_advance: assert property (ce_in && slot_evt && r.st == OSC_S_VERIFY && byte_end
    |=> r.addr == $past(r.addr) + 16'h0001 && r.crc == r.addr[7:0] && r.st == OSC_S_DATA)
    else $error("address or crc preload wrong after verify");
  a_ctrl_only_5a: assert property (ce_in && slot_evt && r.st == OSC_S_PCTL && byte_end
    && rx_byte != OSC_OP_PROG_CTRL |=> r.st == OSC_S_IDLE)
    else $error("bad program control byte accepted");
  a_field_end_crc: assert property (ce_in && slot_evt && r.st == OSC_S_RDATA && byte_end
    && r.addr[2:0] == OSC_LAST_INDEX |=> r.st == OSC_S_RCRC)
    else $error("trailing crc not started at field end");
  a_prog_on_pulse: assert property (ce_in && r.st == OSC_S_PROG && r.prog_q && !r.prog_s1 && !reset_evt
    |=> r.prog_go ##1 r.st == OSC_S_VERIFY)
    else $error("programming pulse end not acted on");

  c_status_read: cover property (r.st == OSC_S_RCRC ##[1:1000] r.st == OSC_S_IDLE);
  c_status_prog: cover property (r.prog_go);
  c_second_byte: cover property (r.st == OSC_S_VERIFY ##[1:1000] r.st == OSC_S_DATA);
  c_profile: cover property (r.st == OSC_S_PROFILE);

endmodule

// File: tb/osc_host_model.sv
// single-wire bus host model: reset pulse, write and read slots, programming pulse
`timescale 1ns/1ps
module osc_host_model (
  input  wire logic sys_clk_in,
  input  wire logic dev_oe_in,
  output logic      line_out,
  output logic      prog_level_out
);
  logic pull;

  // pull-up idle level unless either party pulls low
  assign line_out = ~(pull | dev_oe_in);

  initial begin
    pull = 1'b0;
    prog_level_out = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // long low aborts anything, then wait out the presence answer
  task automatic bus_reset(input int low_cyc, output logic seen);
    pull <= 1'b1;
    hold(low_cyc);
    pull <= 1'b0;
    for (int w = 0; w < 3000 && !dev_oe_in; w++) hold(1);
    seen = dev_oe_in;
    for (int w = 0; w < 3000 && dev_oe_in; w++) hold(1);
    hold(20);
  endtask

  // lsb first; a short low is a one, 60 cycles clears the bench's 40-cycle threshold
  task automatic write_byte(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      pull <= 1'b1;
      hold(b[i] ? 10 : 60);
      pull <= 1'b0;
      hold(30);
    end
  endtask

  // held low past the device's 3-cycle answer so a zero shows no glitch
  task automatic read_byte(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      pull <= 1'b1;
      hold(10);
      pull <= 1'b0;
      hold(60);
      v[i] = line_out;
      for (int w = 0; w < 2000 && !line_out; w++) hold(1);
      hold(30);
    end
  endtask

  // programming level after the control byte, then back to idle
  task automatic prog_pulse();
    prog_level_out <= 1'b1;
    hold(100);
    prog_level_out <= 1'b0;
    hold(20);
  endtask
endmodule

// File: tb/otp_status_field_commands_tb.sv
// self-checking bench for the status-field command block
`timescale 1ns/1ps
module otp_status_field_commands_tb;
  import osc_pkg::*;

  // shortened timing keeps the run short; reset threshold stays above the 150-cycle read-zero hold
  localparam logic [15:0] RST_CYC = 16'h00c8;
  logic       sys_clk_in;
  logic       reset_in;
  logic       line;
  logic       prog_level;
  logic       oe;
  logic [7:0] stat [8];
  int         errors;
  int         cmp_count;
  int         seed;

  osc_status_cmd #(
    .RESET_CYC     (RST_CYC),
    .PRES_LEN_CYC  (16'h0064),
    .WR0_CYC       (16'h0028),
    .TX_HOLD_CYC   (16'h0096),
    .PRES_WAIT_CYC (16'h003c)
  ) dut (
    .sys_clk_in    (sys_clk_in),
    .reset_in      (reset_in),
    .ce_in         (1'b1),
    .data_line_in  (line),
    .prog_level_in (prog_level),
    .data_out      (),
    .data_oe_out   (oe)
  );

  osc_host_model host (
    .sys_clk_in     (sys_clk_in),
    .dev_oe_in      (oe),
    .line_out       (line),
    .prog_level_out (prog_level)
  );

  // reflected x^8 + x^5 + x^4 + 1, lsb first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      c = (c >> 1) ^ ((c[0] ^ b[i]) ? 8'h8c : 8'h00);
    return c;
  endfunction

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    if (errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // reset pulse, presence, skip rom, then a function opcode
  task automatic start(input logic [7:0] op);
    logic seen;
    host.bus_reset(int'(RST_CYC) + 50, seen);
    check("presence", 8'h01, {7'h00, seen});
    host.write_byte(8'hcc, 8);
    host.write_byte(op, 8);
  endtask

  // data byte, crc, control byte, pulse, verify; crc is the generator start value
  task automatic prog_byte(input logic [7:0] a, input logic [7:0] d, input logic [7:0] crc);
    logic [7:0] r;
    host.write_byte(d, 8);
    host.read_byte(r);
    check("write crc", crc8(crc, d), r);
    host.write_byte(8'h5a, 8);
    host.prog_pulse();
    if (a[2:0] != 3'h7)
      stat[a[2:0]] &= d;
    host.read_byte(r);
    check("verify byte", stat[a[2:0]], r);
  endtask

  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  // about 30k cycles expected, so 60k cycles is a hang
  initial begin
    #1200000;
    errors++;
    results();
  end

  initial begin
    logic [7:0] a, r, c, rl;
    int i;
    seed = 32'h80d2b100;
    errors = 0;
    cmp_count = 0;
    reset_in = 1'b1;
    for (i = 0; i < 8; i++) stat[i] = (i == 7) ? 8'h00 : 8'hff;
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    @(posedge sys_clk_in);
    // two bytes in one write; index 6 start lands the second on the fixed byte
    a = 8'(5 + ($random(seed) & 1));
    start(OSC_OP_WRITE_STAT);
    host.write_byte(a, 8);
    host.write_byte(8'h00, 8);
    c = crc8(crc8(crc8(8'h00, 8'h55), a), 8'h00);
    prog_byte(a, 8'($random(seed)), c);
    prog_byte(a + 8'h01, 8'($random(seed)), a + 8'h01);
    // abort in mid byte; the next command must start clean
    host.write_byte(8'h00, 4);
    // status read with junk in the upper address bits
    rl = {5'($random(seed)), a[2:0]};
    start(OSC_OP_READ_STAT);
    host.write_byte(rl, 8);
    host.write_byte(8'h00, 8);
    host.read_byte(r);
    check("read cmd crc", crc8(crc8(crc8(8'h00, 8'haa), rl), 8'h00), r);
    c = 8'h00;
    for (i = int'(a[2:0]); i < 8; i++) begin
      host.read_byte(r);
      check("status byte", stat[i], r);
      c = crc8(c, stat[i]);
    end
    host.read_byte(r);
    check("status crc", c, r);
    host.read_byte(r);
    check("after crc", 8'hff, r);
    // reset in mid read, then the profile query
    rl = 8'($random(seed));
    start(OSC_OP_READ_STAT);
    host.write_byte(rl, 8);
    host.write_byte(8'h00, 8);
    host.read_byte(r);
    check("abort read crc", crc8(crc8(crc8(8'h00, 8'haa), rl), 8'h00), r);
    start(OSC_OP_PROFILE);
    host.read_byte(r);
    check("profile", 8'h55, r);
    host.read_byte(r);
    check("after profile", 8'hff, r);
    // control byte outside a write sequence leaves the device silent
    start(8'h5a);
    host.read_byte(r);
    check("stray control", 8'hff, r);
    results();
  end
endmodule
